// File: rtl/eeprom_cfg_defs.vh
/*
 Constants for the EEPROM configuration and protection block: register
 indices, field positions, reset values and array geometry.
 Assumes it is included by bare name from the design files under rtl/.
*/
// Function
// - Reset copies every shadow into its volatile register
// - Shadows change only by program or erase
// - Timebase divides selected reference by divider value
// - Security bit zero secures sixteen fixed bytes
// - Secured range refuses program and erase, reads normally
// - Armed security freezes the array-config shadow
// - Armed security rejects bulk and block erase
// - Armed security still allows unprotected byte operations
// - Four ascending 128-byte blocks, one protect bit each
// - Set protect bit blocks program and erase there
// - Protection updates on reset or shadow read
// - Programmed lock bit reloads zero after reset
// - Armed lock blocks divider shadows and divider writes
// - Start needs latch enabled and valid latched address
// - Automatic mode timer ends cycle, clears start
// - Clearing start and latch together clears start only
`ifndef EEPROM_CFG_DEFS_VH
`define EEPROM_CFG_DEFS_VH

// ==================================================
// Register indices (byte address is four times the index)
`define IDX_DIV_SHADOW_HIGH 16'hFF70
`define IDX_DIV_SHADOW_LOW 16'hFF71
`define IDX_DIV_HIGH 16'hFF7A
`define IDX_DIV_LOW 16'hFF7B
`define IDX_CFG_SHADOW 16'hFF7C
`define IDX_CONTROL 16'hFF7D
`define IDX_CFG_ACTIVE 16'hFF7F
`define IDX_ARRAY_BASE 16'h0600
`define ARRAY_BYTES 512

// ==================================================
// Field positions
`define BIT_DIVIDER_LOCK_DISABLE 7
`define BIT_ARRAY_SECURITY_ARM 4
`define BIT_ARRAY_POWER_OFF 5
`define BIT_ERASE_SIZE_SEL_HI 4
`define BIT_ERASE_SIZE_SEL_LO 3
`define BIT_LATCH_ENABLE 2
`define BIT_AUTO_MODE 1
`define BIT_PROGRAM_ERASE_START 0

// ==================================================
// Reset and blank values
`define CONTROL_RESET 8'h00
`define NV_BLANK 8'hFF
`define CFG_SHADOW_FACTORY 8'hF0
`define DIV_HIGH_KEEP_MASK 8'h87
`define SECURE_NIBBLE 5'h0F

// ==================================================
// Operation encodings of the erase size select pair
`define OP_PROGRAM 2'b00
`define OP_BYTE_ERASE 2'b01
`define OP_BLOCK_ERASE 2'b10
`define OP_BULK_ERASE 2'b11

// Latched target kinds
`define TGT_ARRAY 2'b00
`define TGT_DIV_HIGH 2'b01
`define TGT_DIV_LOW 2'b10
`define TGT_CFG 2'b11

// ==================================================
// Timing: timebase period and automatic cycle length in timebase ticks
`define TIMEBASE_US 35
`define AUTO_OP_TICKS 10

`endif

// File: rtl/timebase_divider.v
/*
 Timebase divider: produces one-cycle ticks, one per divisor periods of
 the chosen reference (bus clock or sampled oscillator clock).
 Assumes the oscillator input is synchronous to i_clk and slower than half its rate.
*/
`timescale 1ns/1ps
module timebase_divider #(
    parameter DIV_W = 11
) (
    input wire i_clk,                 // Bus clock
    input wire i_sys_rst,             // Synchronous reset, active high
    input wire i_bus_ref,             // 1 selects bus clock as reference
    input wire i_oscillator_clock,    // Oscillator clock, sampled
    input wire [DIV_W-1:0] i_divisor, // Divider value
    output wire o_tick                // One-cycle timebase pulse
);
    reg osc_prev_reg;
    reg [DIV_W-1:0] cnt_reg;
    reg tick_reg;
    wire ref_en;
    wire [DIV_W-1:0] last_w;

    // Oscillator edge stands in for its clock; bus reference counts every cycle
    assign ref_en = i_bus_ref | (i_oscillator_clock & ~osc_prev_reg);
    // Zero divisor behaves as one so the tick never stalls
    assign last_w = (i_divisor == {DIV_W{1'b0}}) ? {DIV_W{1'b0}} : i_divisor - 1'b1;
    assign o_tick = tick_reg;

    // ==================================================
    // Divide counter
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            osc_prev_reg <= 1'b0;
            cnt_reg <= {DIV_W{1'b0}};
            tick_reg <= 1'b0;
        end
        else
        begin
            osc_prev_reg <= i_oscillator_clock;
            tick_reg <= 1'b0;
            if (ref_en)
            begin
                if (cnt_reg >= last_w)
                begin
                    cnt_reg <= {DIV_W{1'b0}};
                    tick_reg <= 1'b1;
                end
                else
                    cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
endmodule

// File: rtl/eeprom_config_protection.v
/*
 EEPROM configuration and protection block: Avalon-MM slave holding the
 shadow and volatile configuration registers, the 512-byte array, the
 latch/start control and the protection checks on every program or erase.
 Assumes a single bus clock, synchronous reset and a master that holds
 its request until it sees waitrequest low.
*/
`timescale 1ns/1ps
`include "eeprom_cfg_defs.vh"
module eeprom_config_protection #(
    parameter OP_TICKS = `AUTO_OP_TICKS,
    parameter DIV_W = 11
) (
    input wire i_clk,                // Bus clock, 250 MHz
    input wire i_sys_rst,            // Synchronous reset, active high
    input wire [17:0] i_address,     // Byte address
    input wire i_read,               // Read request
    input wire i_write,              // Write request
    input wire [31:0] i_writedata,   // Write data, low byte used
    input wire [3:0] i_byteenable,   // Byte lanes
    output wire [31:0] o_readdata,   // Read data
    output wire o_waitrequest,       // Low for the accepting cycle
    input wire i_oscillator_clock,   // Oscillator reference, sampled
    input wire i_timebase_clock_select, // 1 bus clock, 0 oscillator
    output wire o_hv_active,         // Program/erase cycle running
    output wire o_security_armed     // Array security armed
);
    // ==================================================
    // Nonvolatile shadows: untouched by reset
    reg [7:0] div_sh_hi_reg;
    reg [7:0] div_sh_lo_reg;
    reg [7:0] cfg_sh_reg;
    initial
    begin
        div_sh_hi_reg = `NV_BLANK;
        div_sh_lo_reg = `NV_BLANK;
        cfg_sh_reg = `CFG_SHADOW_FACTORY;
    end

    // Volatile and control state
    reg [7:0] div_hi_reg;
    reg [7:0] div_lo_reg;
    reg [7:0] cfg_act_reg;
    reg array_power_off_reg;
    reg [1:0] erase_size_reg;
    reg latch_enable_reg;
    reg auto_reg;
    reg program_erase_start_reg;
    reg lat_valid_reg;
    reg [8:0] lat_addr_reg;
    reg [1:0] lat_tgt_reg;
    reg [7:0] lat_data_reg;
    reg allowed_reg;
    reg [15:0] op_cnt_reg;
    reg wait_reg;
    reg [7:0] rdata_reg;
    reg [7:0] rdata_next;
    reg sec_out_reg;

    wire [15:0] idx;
    wire acc;
    wire wr;
    wire secure;
    wire [3:0] bp;
    wire div_locked;
    wire in_array;
    wire [8:0] arr_off;
    wire [15:0] arr_off_full;
    wire wr_ctrl;
    wire [7:0] wd;
    wire tb_tick;
    wire auto_done;
    wire sw_stop;
    wire commit;
    wire [4095:0] cells;
    wire [7:0] ctrl_rst_w;
    reg req_ok;

    // ==================================================
    // Bus decode; a request is acted on at the edge where waitrequest is low
    assign idx = i_address[17:2];
    assign acc = (i_read | i_write) & ~wait_reg;
    assign wr = acc & i_write & i_byteenable[0];
    assign wd = i_writedata[7:0];
    assign arr_off_full = idx - `IDX_ARRAY_BASE;
    assign arr_off = arr_off_full[8:0];
    assign in_array = (idx >= `IDX_ARRAY_BASE) && (arr_off_full < `ARRAY_BYTES);
    assign wr_ctrl = wr && (idx == `IDX_CONTROL);

    // Protection state
    assign secure = ~cfg_sh_reg[`BIT_ARRAY_SECURITY_ARM];
    assign bp = cfg_act_reg[3:0];
    assign div_locked = ~div_hi_reg[`BIT_DIVIDER_LOCK_DISABLE];
    assign o_readdata = {24'h000000, rdata_reg};
    assign o_waitrequest = wait_reg;
    assign o_hv_active = program_erase_start_reg;
    assign o_security_armed = sec_out_reg;
    // Control reset word, sliced per field so no bits are dropped silently
    assign ctrl_rst_w = `CONTROL_RESET;

    // ==================================================
    // Timebase and end of cycle
    timebase_divider #(
        .DIV_W(DIV_W)
    ) u_timebase (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_bus_ref(i_timebase_clock_select),
        .i_oscillator_clock(i_oscillator_clock),
        .i_divisor({div_hi_reg[2:0], div_lo_reg}),
        .o_tick(tb_tick)
    );

    // Automatic end after a fixed count of timebase ticks
    assign auto_done = program_erase_start_reg & auto_reg & tb_tick
        & (op_cnt_reg == OP_TICKS[15:0] - 16'h0001);
    assign sw_stop = wr_ctrl & program_erase_start_reg & ~wd[`BIT_PROGRAM_ERASE_START];
    // The array is altered only when a cycle ends, and only if it was allowed
    assign commit = (auto_done | sw_stop) & allowed_reg;

    // ==================================================
    // Permission check on the latched target at start
    always @*
    begin
        req_ok = 1'b0;
        case (lat_tgt_reg)
            `TGT_ARRAY:
            begin
                if (erase_size_reg[1])
                    req_ok = ~secure & (erase_size_reg[0] | ~bp[lat_addr_reg[8:7]]);
                else
                    req_ok = ~bp[lat_addr_reg[8:7]]
                        & ~(secure & (lat_addr_reg[8:4] == `SECURE_NIBBLE));
            end
            `TGT_CFG:
                req_ok = ~secure & ~erase_size_reg[1];
            default:
                req_ok = ~div_locked & ~erase_size_reg[1];
        endcase
    end

    // ==================================================
    // Array cells: each byte decides for itself whether a commit touches it
    genvar gi;
    generate
        for (gi = 0; gi < `ARRAY_BYTES; gi = gi + 1)
        begin : g_cell
            reg [7:0] cell_reg;
            wire hit;
            wire guarded;
            initial cell_reg = `NV_BLANK;
            assign guarded = bp[gi / 128]
                | (secure && ((gi / 16) == 15));
            assign hit = (lat_tgt_reg == `TGT_ARRAY) && !guarded
                && ((erase_size_reg == `OP_BULK_ERASE)
                || ((erase_size_reg == `OP_BLOCK_ERASE) && (lat_addr_reg[8:7] == gi / 128))
                || (lat_addr_reg == gi));
            assign cells[gi*8 +: 8] = cell_reg;
            always @(posedge i_clk)
            begin
                if (commit && hit)
                    cell_reg <= (erase_size_reg == `OP_PROGRAM) ? (cell_reg & lat_data_reg) : `NV_BLANK;
            end
        end
    endgenerate

    // ==================================================
    // Read mux, captured while waitrequest is still high
    always @*
    begin
        rdata_next = 8'h00;
        if (in_array)
            rdata_next = cells[{arr_off, 3'b000} +: 8];
        else
            case (idx)
                `IDX_DIV_SHADOW_HIGH: rdata_next = div_sh_hi_reg;
                `IDX_DIV_SHADOW_LOW: rdata_next = div_sh_lo_reg;
                `IDX_DIV_HIGH: rdata_next = div_hi_reg & `DIV_HIGH_KEEP_MASK;
                `IDX_DIV_LOW: rdata_next = div_lo_reg;
                `IDX_CFG_SHADOW: rdata_next = cfg_sh_reg;
                `IDX_CONTROL: rdata_next = {2'b00, array_power_off_reg, erase_size_reg,
                    latch_enable_reg, auto_reg, program_erase_start_reg};
                `IDX_CFG_ACTIVE: rdata_next = cfg_act_reg;
                default: rdata_next = 8'h00;
            endcase
    end

    // ==================================================
    // Shadow programming: only a committed cycle changes them
    always @(posedge i_clk)
    begin
        if (commit && (erase_size_reg == `OP_PROGRAM))
        begin
            case (lat_tgt_reg)
                `TGT_DIV_HIGH: div_sh_hi_reg <= div_sh_hi_reg & lat_data_reg;
                `TGT_DIV_LOW: div_sh_lo_reg <= div_sh_lo_reg & lat_data_reg;
                `TGT_CFG: cfg_sh_reg <= cfg_sh_reg & lat_data_reg;
                default: cfg_sh_reg <= cfg_sh_reg;
            endcase
        end
        else if (commit && (erase_size_reg == `OP_BYTE_ERASE))
        begin
            case (lat_tgt_reg)
                `TGT_DIV_HIGH: div_sh_hi_reg <= `NV_BLANK;
                `TGT_DIV_LOW: div_sh_lo_reg <= `NV_BLANK;
                `TGT_CFG: cfg_sh_reg <= `NV_BLANK;
                default: cfg_sh_reg <= cfg_sh_reg;
            endcase
        end
    end

    // ==================================================
    // Bus handshake, volatile registers and control
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 8'h00;
            sec_out_reg <= 1'b0;
            // Volatile registers reload from their shadows on every reset
            div_hi_reg <= div_sh_hi_reg & `DIV_HIGH_KEEP_MASK;
            div_lo_reg <= div_sh_lo_reg;
            cfg_act_reg <= cfg_sh_reg;
            array_power_off_reg <= ctrl_rst_w[`BIT_ARRAY_POWER_OFF];
            erase_size_reg <= {ctrl_rst_w[`BIT_ERASE_SIZE_SEL_HI], ctrl_rst_w[`BIT_ERASE_SIZE_SEL_LO]};
            latch_enable_reg <= ctrl_rst_w[`BIT_LATCH_ENABLE];
            auto_reg <= ctrl_rst_w[`BIT_AUTO_MODE];
            program_erase_start_reg <= ctrl_rst_w[`BIT_PROGRAM_ERASE_START];
            lat_valid_reg <= 1'b0;
            lat_addr_reg <= 9'h000;
            lat_tgt_reg <= `TGT_ARRAY;
            lat_data_reg <= 8'h00;
            allowed_reg <= 1'b0;
            op_cnt_reg <= 16'h0000;
        end
        else
        begin
            // One low cycle of waitrequest per request, data ready with it
            wait_reg <= ~((i_read | i_write) & wait_reg);
            if ((i_read | i_write) & wait_reg)
                rdata_reg <= i_read ? rdata_next : 8'h00;
            sec_out_reg <= secure;

            // Reading the config shadow refreshes the active protection
            if (acc && i_read && (idx == `IDX_CFG_SHADOW))
                cfg_act_reg <= cfg_sh_reg;

            // Divider writes only with latch clear and lock disabled
            if (wr && !latch_enable_reg && !div_locked)
            begin
                if (idx == `IDX_DIV_HIGH)
                    div_hi_reg <= wd & `DIV_HIGH_KEEP_MASK;
                if (idx == `IDX_DIV_LOW)
                    div_lo_reg <= wd;
            end

            // Latch address and data of a write to a valid target
            if (wr && latch_enable_reg && !program_erase_start_reg)
            begin
                if (in_array)
                begin
                    lat_valid_reg <= 1'b1;
                    lat_addr_reg <= arr_off;
                    lat_tgt_reg <= `TGT_ARRAY;
                    lat_data_reg <= wd;
                end
                else if ((idx == `IDX_DIV_SHADOW_HIGH) || (idx == `IDX_DIV_SHADOW_LOW)
                    || (idx == `IDX_CFG_SHADOW))
                begin
                    lat_valid_reg <= 1'b1;
                    lat_addr_reg <= 9'h000;
                    lat_tgt_reg <= (idx == `IDX_CFG_SHADOW) ? `TGT_CFG :
                        ((idx == `IDX_DIV_SHADOW_HIGH) ? `TGT_DIV_HIGH : `TGT_DIV_LOW);
                    lat_data_reg <= wd;
                end
            end

            // Cycle timer counts timebase ticks while start is set
            if (!program_erase_start_reg)
                op_cnt_reg <= 16'h0000;
            else if (tb_tick)
                op_cnt_reg <= op_cnt_reg + 16'h0001;

            if (auto_done)
                program_erase_start_reg <= 1'b0;

            // Control register write
            if (wr_ctrl)
            begin
                array_power_off_reg <= wd[`BIT_ARRAY_POWER_OFF];
                if (program_erase_start_reg)
                begin
                    // Latch, size and mode stay while high voltage decays; only start and power-off may change
                    if (!wd[`BIT_PROGRAM_ERASE_START])
                        program_erase_start_reg <= 1'b0;
                end
                else
                begin
                    erase_size_reg <= {wd[`BIT_ERASE_SIZE_SEL_HI], wd[`BIT_ERASE_SIZE_SEL_LO]};
                    auto_reg <= wd[`BIT_AUTO_MODE];
                    latch_enable_reg <= wd[`BIT_LATCH_ENABLE];
                    if (!wd[`BIT_LATCH_ENABLE])
                        lat_valid_reg <= 1'b0;
                    // Start only with latch already enabled and a target latched
                    if (wd[`BIT_PROGRAM_ERASE_START] && latch_enable_reg && lat_valid_reg)
                    begin
                        program_erase_start_reg <= 1'b1;
                        allowed_reg <= req_ok;
                    end
                end
            end
        end
    end
endmodule

// File: testbench/eeprom_cfg_props.sv
/*
 Checker for the EEPROM configuration block: bus handshake, start and stop
 of program/erase cycles, reset state and the security flag.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`include "eeprom_cfg_defs.vh"
module eeprom_cfg_props #(
    parameter OP_TICKS = 10,
    parameter DIV_W = 11
) (
    input wire i_clk,                   // Bus clock
    input wire i_sys_rst,               // Synchronous reset
    input wire [17:0] i_address,        // Byte address
    input wire i_read,                  // Read request
    input wire i_write,                 // Write request
    input wire [31:0] i_writedata,      // Write data
    input wire [3:0] i_byteenable,      // Byte lanes
    input wire [31:0] o_readdata,       // Read data
    input wire o_waitrequest,           // Slave wait
    input wire i_oscillator_clock,      // Oscillator reference
    input wire i_timebase_clock_select, // Reference select
    input wire o_hv_active,             // Cycle running
    input wire o_security_armed         // Security armed
);
    // ==========================================
    // Helper logic
    logic latch_q;
    wire req = i_read || i_write;
    wire ctrl_acc = i_write && !o_waitrequest && i_address[17:2] == `IDX_CONTROL;
    wire start_wr = ctrl_acc && i_writedata[0];
    wire cfg_rd = i_read && !o_waitrequest && i_address[17:2] == `IDX_CFG_SHADOW;
    // Latch as software last left it; frozen while a cycle runs
    always @(posedge i_clk)
        if (i_sys_rst)
            latch_q <= 1'b0;
        else if (ctrl_acc && !o_hv_active)
            latch_q <= i_writedata[2];

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_take;
        req && o_waitrequest;
    endsequence
    sequence s_stop;
        ctrl_acc && !i_writedata[0] && o_hv_active;
    endsequence
    sequence s_low_rd;
        i_read && o_waitrequest && i_address[17:2] < 16'h0600;
    endsequence

    // ==========================================
    // Properties
    a_ack_one_cycle: assert property (s_take |=> !o_waitrequest ##1 o_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    a_no_idle_ack: assert property (!o_waitrequest |-> $past(req) && $past(o_waitrequest))
        else $error("acknowledge without a request");
    a_reset_idle: assert property ($fell(i_sys_rst) |-> o_waitrequest && !o_hv_active && o_readdata == 32'h0)
        else $error("outputs not idle after reset");
    a_start_cause: assert property ($rose(o_hv_active) |-> $past(start_wr))
        else $error("cycle started without a start write");
    a_start_latched: assert property ($rose(o_hv_active) |-> $past(latch_q))
        else $error("cycle started with latch clear");
    a_stop_clears: assert property (s_stop |=> !o_hv_active)
        else $error("start bit not cleared by control write");
    a_armed_sticky: assert property (o_security_armed |=> o_security_armed)
        else $error("security dropped");
    a_armed_match: assert property (cfg_rd |-> o_security_armed == !o_readdata[4])
        else $error("security flag differs from shadow bit");
    a_unmapped_zero: assert property (s_low_rd |=> o_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind eeprom_config_protection eeprom_cfg_props #(.OP_TICKS(OP_TICKS), .DIV_W(DIV_W)) props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_oscillator_clock(i_oscillator_clock),
    .i_timebase_clock_select(i_timebase_clock_select), .o_hv_active(o_hv_active),
    .o_security_armed(o_security_armed)
);

// File: testbench/cpu_master.sv
/*
 Software side model: a bus master issuing one byte access at a time,
 plus the oscillator reference.
 Assumes its task is entered just after a rising edge of i_clk.
*/
`timescale 1ns/1ps
module cpu_master (
    input wire logic i_clk,             // Bus clock
    input wire logic i_waitrequest,     // Slave wait
    input wire logic [31:0] i_readdata, // Slave read data
    output logic [17:0] o_address,      // Byte address
    output logic o_read,                // Read request
    output logic o_write,               // Write request
    output logic [31:0] o_writedata,    // Write data
    output logic o_oscillator_clock     // 12.5 MHz reference
);
    // ==========================================
    // Oscillator, toggling on falling edges of the bus clock
    initial o_oscillator_clock = 1'b0;
    always #40 o_oscillator_clock = ~o_oscillator_clock;
    // Idle bus at time zero
    initial
    begin
        o_address = 18'h0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
    end
    // Request held until waitrequest is sampled low; data taken at that edge
    task automatic xfer(input bit w, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q);
        int n;
        begin
            n = 0;
            o_address <= {idx, 2'b00};
            o_writedata <= {24'h0, d};
            o_read <= !w;
            o_write <= w;
            @(posedge i_clk);
            while (i_waitrequest !== 1'b0 && n < 100)
            begin
                @(posedge i_clk);
                n++;
            end
            if (n == 100)
                testbench.complete_run(1'b1);
            else
            begin
                q = i_readdata[7:0];
                o_read <= 1'b0;
                o_write <= 1'b0;
                @(posedge i_clk);
            end
        end
    endtask
endmodule

// File: testbench/testbench.sv
/*
 Testbench for the EEPROM configuration block: reset copies, cycles in both
 modes, block protection, security and divider lock.
 Assumes the cpu_master model and the bound checker.
*/
`timescale 1ns/1ps
`include "eeprom_cfg_defs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    localparam logic [10:0] DIVISOR = 11'd438; // 12.5 MHz times 35 us plus a half, truncated
    localparam logic [15:0] CTRL = `IDX_CONTROL;
    localparam logic [15:0] CFG = `IDX_CFG_SHADOW;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic sel = 1'b0;
    wire [17:0] address;
    wire read, write, waitreq, osc, hv, armed;
    wire [31:0] writedata, readdata;
    int fail_count = 0;
    int n_checks = 0;
    int n;
    logic [7:0] q;
    // ==========================================
    // Clock, design and software model
    always #2 i_clk = ~i_clk;
    eeprom_config_protection #(.OP_TICKS(2), .DIV_W(11)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(address), .i_read(read), .i_write(write),
        .i_writedata(writedata), .i_byteenable(4'hF), .o_readdata(readdata), .o_waitrequest(waitreq),
        .i_oscillator_clock(osc), .i_timebase_clock_select(sel), .o_hv_active(hv),
        .o_security_armed(armed)
    );
    cpu_master m (
        .i_clk(i_clk), .i_waitrequest(waitreq), .i_readdata(readdata), .o_address(address),
        .o_read(read), .o_write(write), .o_writedata(writedata), .o_oscillator_clock(osc)
    );
    // ==========================================
    // Tasks
    task automatic complete_run(input bit hang);
        if (hang)
            fail_count++;
        if (fail_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset();
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        m.xfer(1'b1, idx, d, q);
    endtask
    task automatic rc(input logic [15:0] idx, input logic [7:0] e);
        m.xfer(1'b0, idx, 8'h00, q);
        `CHK(q, e)
    endtask
    // Latch, load target, start; auto waits for the timer, manual clears start
    task automatic prog(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] ras, input bit aut);
        logic [7:0] c;
        begin
            c = {3'b000, ras, 1'b1, aut, 1'b0};
            wr(CTRL, c);
            wr(idx, d);
            wr(CTRL, c | 8'h01);
            n = 0;
            while (aut && hv !== 1'b0 && n < 20000)
            begin
                @(posedge i_clk);
                n++;
            end
            if (n == 20000)
                complete_run(1'b1);
            if (!aut)
                wr(CTRL, 8'h00);
            m.xfer(1'b0, CTRL, 8'h00, q);
            `CHK(q & 8'h07, aut ? 8'h06 : 8'h04)
            wr(CTRL, 8'h00);
        end
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        do_reset();
        rc(16'hFF7A, 8'h87);
        rc(16'hFF7B, 8'hFF);
        rc(16'hFF7F, 8'hF0);
        rc(CTRL, 8'h00);
        rc(16'h0100, 8'h00);
        wr(CFG, 8'h00);
        rc(CFG, 8'hF0);
        wr(CTRL, 8'h01);
        `CHK(hv, 1'b0)
        // Divider set before any cycle; oscillator reference selected
        wr(16'hFF7A, {5'h10, DIVISOR[10:8]});
        wr(16'hFF7B, DIVISOR[7:0]);
        rc(16'hFF7A, 8'h81);
        prog(16'h0600, 8'hA5, 2'b00, 1'b1);
        `CHK(n >= 8700 && n <= 17600, 1'b1)
        rc(16'h0600, 8'hA5);
        // Bus clock reference: same divisor, twenty times fewer cycles per tick
        sel <= 1'b1;
        prog(16'h0602, 8'h5A, 2'b00, 1'b1);
        `CHK(n >= 430 && n <= 890, 1'b1)
        rc(16'h0602, 8'h5A);
        prog(16'h0601, 8'h3C, 2'b00, 1'b0);
        rc(16'h0601, 8'h3C);
        // New protect bits wait for a shadow read; programming only clears bits, so erase first
        prog(CFG, 8'h00, 2'b01, 1'b0);
        prog(CFG, 8'hF1, 2'b00, 1'b0);
        rc(16'hFF7F, 8'hF0);
        rc(CFG, 8'hF1);
        rc(16'hFF7F, 8'hF1);
        prog(16'h067F, 8'h00, 2'b00, 1'b0);
        rc(16'h067F, 8'hFF);
        prog(16'h0680, 8'h12, 2'b00, 1'b0);
        rc(16'h0680, 8'h12);
        // Security armed: secured range, erases and shadow frozen
        prog(CFG, 8'hE1, 2'b00, 1'b0);
        `CHK(armed, 1'b1)
        prog(16'h06F0, 8'h00, 2'b00, 1'b0);
        rc(16'h06F0, 8'hFF);
        prog(16'h06EF, 8'h55, 2'b00, 1'b0);
        rc(16'h06EF, 8'h55);
        prog(16'h06EF, 8'h00, 2'b11, 1'b0);
        rc(16'h06EF, 8'h55);
        prog(16'h0680, 8'h00, 2'b10, 1'b0);
        rc(16'h0680, 8'h12);
        prog(CFG, 8'h00, 2'b01, 1'b0);
        rc(CFG, 8'hE1);
        // Divider lock armed by the shadow and a reset
        prog(`IDX_DIV_SHADOW_HIGH, 8'h01, 2'b00, 1'b0);
        do_reset();
        rc(16'hFF7A, 8'h01);
        rc(16'hFF7F, 8'hE1);
        wr(16'hFF7B, 8'h33);
        rc(16'hFF7B, 8'hFF);
        prog(`IDX_DIV_SHADOW_LOW, 8'h00, 2'b00, 1'b0);
        rc(`IDX_DIV_SHADOW_LOW, 8'hFF);
        `CHK(armed, 1'b1)
        complete_run(1'b0);
    end
endmodule
